// >>> tb_usi_intr_div.sv
`timescale 1ns/1ps
module tb_usi_intr_div;
   reg        sys_clk = 1'b0;
   reg        resetn = 1'b0;
   reg        divAccess = 1'b0;
   reg        fifoEnable = 1'b0;
   reg        out2Gate = 1'b1;
   reg  [7:0] rxChar = 8'hA5;
   reg        rxDataReady = 1'b0;
   reg        rxBelow = 1'b1;
   reg        lineError = 1'b0;
   reg        modemChange = 1'b0;
   reg        thrEmpty = 1'b0;
   reg        rxPush = 1'b0;
   reg  [7:0] d;
   wire [2:0] addr;
   wire [7:0] wrData, rdData;
   wire       rdStrobe, wrStrobe, baudTick, chipIntr, intrRequest, rxPop, thrWrite;
   integer    badCount = 0;
   integer    testsRun = 0;
   integer    n;
   always #5 sys_clk = ~sys_clk;
   usi_host i_host (.sys_clk, .rdData, .addr, .rdStrobe, .wrStrobe, .wrData);
   usi_intr_div i_dut (.sys_clk, .resetn, .addr, .rdStrobe, .wrStrobe, .wrData,
      .divisor_access_select(divAccess), .fifoEnable, .out2Gate, .rxChar, .rxDataReady,
      .rxPush, .rxBelowTrigger(rxBelow), .lineError, .modemChange, .thrEmpty,
      .rdData, .baudTick, .chipIntr, .intrRequest, .rxPop, .thrWrite);
   task stopTest;
      begin
         $display("checks %0d mismatches %0d", testsRun, badCount);
         if (badCount == 0 && testsRun > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         testsRun = testsRun + 1;
         if (got !== exp) begin
            badCount = badCount + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task rdChk(input [2:0] a, input [7:0] exp);
      begin
         i_host.rd(a, d);
         chk(d, exp);
      end
   endtask
   task idle(input integer k);
      repeat (k) @(negedge sys_clk);
   endtask
   // counts edges up to the next tick; a dead generator ends the run
   task waitTick;
      begin
         n = 0;
         do begin
            @(negedge sys_clk);
            n = n + 1;
         end while (baudTick !== 1'b1 && n < 300);
         chk((n < 300) ? 8'h01 : 8'h00, 8'h01);
         if (n >= 300)
            stopTest;
      end
   endtask
   task test_divisor;
      begin
         rdChk(3'h2, 8'h01);
         divAccess = 1'b1;
         i_host.wr(3'h0, 8'h06);
         i_host.wr(3'h1, 8'h01);
         divAccess = 1'b0;
         i_host.wr(3'h1, 8'hFF);
         rdChk(3'h1, 8'h0F);
         divAccess = 1'b1;
         rdChk(3'h1, 8'h01);
         rdChk(3'h0, 8'h06);
         waitTick;
         waitTick;
         chk(n[7:0], 8'h06);
         chk(n[15:8], 8'h01);
         i_host.wr(3'h1, 8'h00);
         waitTick;
         chk((n <= 8) ? 8'h01 : 8'h00, 8'h01);
         waitTick;
         chk(n[7:0], 8'h06);
         divAccess = 1'b0;
         $display("divisor test done");
      end
   endtask
   task test_priority;
      begin
         thrEmpty = 1'b1;
         rxDataReady = 1'b1;
         lineError = 1'b1;
         modemChange = 1'b1;
         idle(1);
         lineError = 1'b0;
         modemChange = 1'b0;
         idle(3);
         chk({7'h00, intrRequest}, 8'h01);
         rdChk(3'h2, 8'h06);
         i_host.rd(3'h5, d);
         rdChk(3'h2, 8'h04);
         rdChk(3'h0, 8'hA5);
         chk({7'h00, rxPop}, 8'h01);
         rxDataReady = 1'b0;
         rdChk(3'h2, 8'h02);
         thrEmpty = 1'b0;
         rdChk(3'h2, 8'h00);
         i_host.rd(3'h6, d);
         rdChk(3'h2, 8'h01);
         $display("priority test done");
      end
   endtask
   task test_mask;
      begin
         i_host.wr(3'h1, 8'h00);
         lineError = 1'b1;
         modemChange = 1'b1;
         thrEmpty = 1'b1;
         idle(1);
         lineError = 1'b0;
         modemChange = 1'b0;
         idle(3);
         chk({7'h00, chipIntr}, 8'h00);
         rdChk(3'h2, 8'h01);
         i_host.wr(3'h1, 8'h08);
         rdChk(3'h2, 8'h00);
         i_host.wr(3'h1, 8'h0A);
         rdChk(3'h2, 8'h02);
         rdChk(3'h2, 8'h00);
         i_host.wr(3'h1, 8'h0E);
         rdChk(3'h2, 8'h06);
         out2Gate = 1'b0;
         idle(2);
         chk({6'h00, chipIntr, intrRequest}, 8'h02);
         out2Gate = 1'b1;
         i_host.rd(3'h5, d);
         i_host.rd(3'h6, d);
         thrEmpty = 1'b0;
         idle(1);
         thrEmpty = 1'b1;
         idle(3);
         chk({7'h00, chipIntr}, 8'h01);
         i_host.wr(3'h0, 8'h3C);
         chk({7'h00, thrWrite}, 8'h01);
         rdChk(3'h2, 8'h01);
         $display("mask test done");
      end
   endtask
   task test_timeout;
      begin
         i_host.wr(3'h1, 8'h01);
         fifoEnable = 1'b1;
         idle(1);
         rxDataReady = 1'b1;
         rdChk(3'h2, 8'hC1);
         // a push part way through must restart the idle count
         idle(2000);
         rxPush = 1'b1;
         idle(1);
         rxPush = 1'b0;
         n = 0;
         while (chipIntr !== 1'b1 && n < 5000) begin
            @(negedge sys_clk);
            n = n + 1;
         end
         chk((n > 3000 && n < 5000) ? 8'h01 : 8'h00, 8'h01);
         if (n >= 5000)
            stopTest;
         rdChk(3'h2, 8'hCC);
         rdChk(3'h0, 8'hA5);
         rdChk(3'h2, 8'hC1);
         rxBelow = 1'b0;
         idle(2);
         rdChk(3'h2, 8'hC4);
         rxBelow = 1'b1;
         idle(2);
         rdChk(3'h2, 8'hC1);
         $display("timeout test done");
      end
   endtask
   initial begin
      idle(3);
      resetn = 1'b1;
      test_divisor;
      test_priority;
      test_mask;
      test_timeout;
      stopTest;
   end
endmodule

// >>> usi_baud_gen.v
`timescale 1ns/1ps
`include "usi_regs.vh"
module usi_baud_gen #(
   parameter WIDTH = 16
) (
   input  wire             sys_clk,
   input  wire             resetn,
   input  wire [WIDTH-1:0] divisor,
   input  wire             reload,
   output reg              tick16
);
   reg [WIDTH-1:0] count;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count  <= {WIDTH{1'b0}};
         tick16 <= 1'b0;
      end else if (reload) begin
         // fresh divisor starts at once, no long stale count
         count  <= divisor;
         tick16 <= 1'b0;
      end else if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
         // one pulse per divisor clocks = sixteen per bit
         count  <= divisor;
         tick16 <= (divisor != {WIDTH{1'b0}});
      end else begin
         count  <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         tick16 <= 1'b0;
      end
   end
endmodule

// >>> usi_host.sv
`timescale 1ns/1ps
module usi_host (
   input  wire       sys_clk,
   input  wire [7:0] rdData,
   output reg  [2:0] addr = 3'h7,
   output reg        rdStrobe = 1'b0,
   output reg        wrStrobe = 1'b0,
   output reg  [7:0] wrData = 8'h00
);
   // each request is taken at one rising edge; no wait states exist
   task wr(input [2:0] a, input [7:0] d);
      begin
         @(negedge sys_clk);
         addr = a;
         wrData = d;
         wrStrobe = 1'b1;
         @(negedge sys_clk);
         wrStrobe = 1'b0;
         wrData = ~d; // released data must not look valid
      end
   endtask
   task rd(input [2:0] a, output [7:0] d);
      begin
         @(negedge sys_clk);
         addr = a;
         rdStrobe = 1'b1;
         @(negedge sys_clk);
         rdStrobe = 1'b0;
         d = rdData;
      end
   endtask
endmodule

// >>> usi_intr_div.v
`timescale 1ns/1ps
`include "usi_regs.vh"
// Notes on behaviour
// - receive data bit 0 is first bit received
// - two divisor bytes form sixteen-bit clock divisor
// - divided clock runs sixteen times baud rate
// - enable bit 3 gates modem status source
// - enable bit 2 gates line status source
// - enable bit 1 gates transmit empty source
// - enable bit 0 gates data, timeout; 7:4 zero
// - all enables clear blocks interrupt; status continues
// - priority: line, data/timeout, transmit empty, modem
// - identification held while being read
// - bits 7,6 read one in fifo mode
// - bit 3 marks timeout in fifo mode only
// - bit 0 low while an enabled interrupt pends
// - line error gives 0110, cleared by status read
// - four idle character times give 1100
// - modem change gives 0000, cleared by status read
// - divisor write reloads baud counter immediately
// - divisor bytes reached only with access bit set
// - intrRequest leaves only while out2 gate set; chipIntr is not gated
module usi_intr_div #(
   parameter DIVW   = 16,
   parameter FIFO_OK = 1'b1
) (
   input  wire       sys_clk,
   input  wire       resetn,
   input  wire [2:0] addr,
   input  wire       rdStrobe,
   input  wire       wrStrobe,
   input  wire [7:0] wrData,
   input  wire       divisor_access_select,
   input  wire       fifoEnable,
   input  wire       out2Gate,
   input  wire [7:0] rxChar,
   input  wire       rxDataReady,
   input  wire       rxPush,
   input  wire       rxBelowTrigger,
   input  wire       lineError,
   input  wire       modemChange,
   input  wire       thrEmpty,
   output reg  [7:0] rdData,
   output reg        baudTick,
   output reg        chipIntr,
   output reg        intrRequest,
   output reg        rxPop,
   output reg        thrWrite
);
   reg  [7:0]      divLow;
   reg  [7:0]      divHigh;
   reg  [3:0]      enable;
   reg             lineFlag;
   reg             modemFlag;
   reg             thrFlag;
   reg  [3:0]      heldId;
   reg             thrPrev;
   reg             divReload;
   reg  [3:0]      next_id;
   wire            tick16;
   wire            tmoExpired;
   wire [DIVW-1:0] divisor;
   wire            rdData0;
   wire            wrData0;
   wire            rdEnable;
   wire            wrEnable;
   wire            rdIdent;
   wire            rdLine;
   wire            rdModem;
   wire            rxAvail;
   wire            tmoPend;

   // decode one offset, with or without the divisor window
   function hit;
      input [2:0] a;
      input [2:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   assign rdData0  = rdStrobe && hit(addr, `USI_OFS_DATA) && !divisor_access_select;
   assign wrData0  = wrStrobe && hit(addr, `USI_OFS_DATA) && !divisor_access_select;
   assign rdEnable = rdStrobe && hit(addr, `USI_OFS_ENABLE);
   assign wrEnable = wrStrobe && hit(addr, `USI_OFS_ENABLE);
   assign rdIdent  = rdStrobe && hit(addr, `USI_OFS_IDENT);
   assign rdLine   = rdStrobe && hit(addr, `USI_OFS_LINESTAT);
   assign rdModem  = rdStrobe && hit(addr, `USI_OFS_MODEMSTAT);
   assign divisor  = {divHigh, divLow};
   assign rxAvail  = fifoEnable ? !rxBelowTrigger : rxDataReady;
   assign tmoPend  = fifoEnable && tmoExpired;

   usi_baud_gen #(
      .WIDTH (DIVW)
   ) u_baud (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .divisor (divisor),
      .reload  (divReload),
      .tick16  (tick16)
   );

   usi_timeout #(
      .CW (10)
   ) u_tmo (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .tick16   (tick16),
      .active   (fifoEnable && rxDataReady),
      .activity (rxPush || rdData0),
      .expired  (tmoExpired)
   );

   // registers and sticky sources; a new event beats a clear
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {divHigh, divLow} <= `USI_DIV_RESET;
         enable    <= `USI_EN_RESET;
         lineFlag  <= 1'b0;
         modemFlag <= 1'b0;
         thrFlag   <= 1'b0;
         // holding register starts empty, so no false edge after reset
         thrPrev   <= 1'b1;
         divReload <= 1'b0;
      end else begin
         divReload <= 1'b0;
         if (wrStrobe && divisor_access_select && hit(addr, `USI_OFS_DATA)) begin
            divLow    <= wrData;
            divReload <= 1'b1;
         end
         if (wrStrobe && divisor_access_select && hit(addr, `USI_OFS_ENABLE)) begin
            divHigh   <= wrData;
            divReload <= 1'b1;
         end
         if (wrEnable && !divisor_access_select) begin
            enable <= wrData[3:0];
         end
         // line status keeps latching even with enables off
         lineFlag  <= lineError || (lineFlag && !rdLine);
         modemFlag <= modemChange || (modemFlag && !rdModem);
         // only a fresh empty edge arms, so a serviced flag stays down while empty
         thrPrev <= thrEmpty;
         if (thrEmpty && !thrPrev) begin
            thrFlag <= 1'b1;
         end else if (wrData0 || (rdIdent && heldId == `USI_ID_THRE)) begin
            thrFlag <= 1'b0;
         end
      end
   end

   // priority encoder over enabled sources
   always @* begin
      next_id = `USI_ID_NONE;
      if (enable[`USI_EN_LINE] && lineFlag) begin
         next_id = `USI_ID_LINE;
      end else if (enable[`USI_EN_RXDATA] && rxAvail) begin
         next_id = `USI_ID_RXDATA;
      end else if (enable[`USI_EN_RXDATA] && tmoPend) begin
         next_id = `USI_ID_TIMEOUT;
      end else if (enable[`USI_EN_THRE] && thrFlag) begin
         next_id = `USI_ID_THRE;
      end else if (enable[`USI_EN_MODEM] && modemFlag) begin
         next_id = `USI_ID_MODEM;
      end
   end

   // id freezes while the host reads it, so a late source cannot tear it
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         heldId  <= `USI_ID_NONE;
      end else begin
         if (!rdIdent) begin
            heldId <= next_id;
         end
      end
   end

   // read mux and outputs, all registered
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdData      <= 8'h00;
         baudTick    <= 1'b0;
         chipIntr    <= 1'b0;
         intrRequest <= 1'b0;
         rxPop       <= 1'b0;
         thrWrite    <= 1'b0;
      end else begin
         baudTick    <= tick16;
         chipIntr    <= (heldId != `USI_ID_NONE);
         intrRequest <= (heldId != `USI_ID_NONE) && out2Gate;
         rxPop       <= rdData0;
         thrWrite    <= wrData0;
         rdData      <= 8'h00;
         if (rdStrobe) begin
            case (addr)
               `USI_OFS_DATA:
                  rdData <= divisor_access_select ? divLow : rxChar;
               `USI_OFS_ENABLE:
                  rdData <= divisor_access_select ? divHigh : {4'h0, enable};
               `USI_OFS_IDENT:
                  rdData <= {fifoEnable & FIFO_OK, fifoEnable & FIFO_OK, 2'b00,
                             heldId[3] & fifoEnable, heldId[2:0]};
               default:
                  rdData <= 8'h00;
            endcase
         end
      end
   end
endmodule

// >>> usi_intr_div_assertions.sv
`timescale 1ns/1ps
module usi_intr_div_assertions #(
   parameter FIFO_OK = 1'b1
) (
   input wire       sys_clk,
   input wire       resetn,
   input wire [2:0] addr,
   input wire       rdStrobe,
   input wire       wrStrobe,
   input wire       divisor_access_select,
   input wire       fifoEnable,
   input wire       out2Gate,
   input wire [7:0] rxChar,
   input wire [7:0] rdData,
   input wire       chipIntr,
   input wire       intrRequest,
   input wire       rxPop,
   input wire       thrWrite
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence rxRead;
      rdStrobe && addr == 3'h0 && !divisor_access_select;
   endsequence
   sequence idRead;
      rdStrobe && addr == 3'h2;
   endsequence
   AST_RXDATA: assert property (rxRead |=> rdData == $past(rxChar))
      else $error("receive data read wrong");
   AST_POP: assert property (rxPop == $past(rdStrobe && addr == 3'h0 && !divisor_access_select))
      else $error("receive pop wrong");
   AST_THRW: assert property (thrWrite == $past(wrStrobe && addr == 3'h0 && !divisor_access_select))
      else $error("transmit write wrong");
   AST_IDPEND: assert property (idRead ##1 $stable(chipIntr) |-> rdData[0] == !chipIntr)
      else $error("pending bit wrong");
   AST_FIFOBITS: assert property (idRead |=> rdData[7:4] == ($past(fifoEnable) ? {FIFO_OK, FIFO_OK, 2'b00} : 4'h0))
      else $error("mode bits wrong");
   AST_BIT3: assert property (rdStrobe && addr == 3'h2 && !fifoEnable |=> !rdData[3])
      else $error("timeout bit in character mode");
   AST_ENRSV: assert property (rdStrobe && addr == 3'h1 && !divisor_access_select |=> rdData[7:4] == 4'h0)
      else $error("enable upper bits not zero");
   AST_GATE: assert property (intrRequest |-> chipIntr && $past(out2Gate))
      else $error("interrupt passed closed gate");
endmodule
bind usi_intr_div usi_intr_div_assertions #(.FIFO_OK(FIFO_OK)) i_chk (.sys_clk, .resetn, .addr,
   .rdStrobe, .wrStrobe, .divisor_access_select, .fifoEnable, .out2Gate, .rxChar, .rdData,
   .chipIntr, .intrRequest, .rxPop, .thrWrite);

// >>> usi_regs.vh
`ifndef USI_REGS_VH
`define USI_REGS_VH
// register offsets (low three address bits of the port block)
`define USI_OFS_DATA      3'h0
`define USI_OFS_ENABLE    3'h1
`define USI_OFS_IDENT     3'h2
`define USI_OFS_LINECTL   3'h3
`define USI_OFS_MODEMCTL  3'h4
`define USI_OFS_LINESTAT  3'h5
`define USI_OFS_MODEMSTAT 3'h6
// field positions
`define USI_EN_RXDATA     0
`define USI_EN_THRE       1
`define USI_EN_LINE       2
`define USI_EN_MODEM      3
`define USI_LCR_DIVACC    7
`define USI_MCR_OUT2      3
// identification codes, bits 3..0
`define USI_ID_NONE       4'h1
`define USI_ID_LINE       4'h6
`define USI_ID_RXDATA     4'h4
`define USI_ID_TIMEOUT    4'hC
`define USI_ID_THRE       4'h2
`define USI_ID_MODEM      4'h0
// reset values
`define USI_DIV_RESET     16'h0000
`define USI_EN_RESET      4'h0
// timing
`define USI_OVERSAMPLE    16
`define USI_TIMEOUT_CHARS 4
`define USI_BITS_PER_CHAR 10
`endif

// >>> usi_timeout.v
`timescale 1ns/1ps
`include "usi_regs.vh"
module usi_timeout #(
   parameter CW = 10
) (
   input  wire sys_clk,
   input  wire resetn,
   input  wire tick16,
   input  wire active,
   input  wire activity,
   output reg  expired
);
   localparam [CW-1:0] LIMIT =
      `USI_OVERSAMPLE * `USI_BITS_PER_CHAR * `USI_TIMEOUT_CHARS;
   reg [CW-1:0] count;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count   <= {CW{1'b0}};
         expired <= 1'b0;
      end else if (!active || activity) begin
         // any push or pop restarts the wait
         count   <= {CW{1'b0}};
         expired <= 1'b0;
      end else if (tick16 && !expired) begin
         count   <= count + {{(CW-1){1'b0}}, 1'b1};
         expired <= (count == LIMIT - {{(CW-1){1'b0}}, 1'b1});
      end
   end
endmodule
